// ===== verilog/uir_cfg.svh
// Offsets, field positions, reset values and timing counts of the interrupt source block
`ifndef UIR_CFG_SVH
`define UIR_CFG_SVH

`define UIR_CLK_HZ        40000000
`define UIR_T128_NS       128000
`define UIR_T1024_NS      1024000
`define UIR_BRST_NS       256000
// Period counts round down, least detect time rounds up
`define UIR_T128_CYC      ((`UIR_T128_NS * (`UIR_CLK_HZ / 1000000)) / 1000)
`define UIR_T1024_DIV     (`UIR_T1024_NS / `UIR_T128_NS)
`define UIR_BRST_CYC      ((`UIR_BRST_NS * (`UIR_CLK_HZ / 1000000) + 999) / 1000)

`define UIR_IDX_PA_EN     8'h04
`define UIR_IDX_PB_EN     8'h05
`define UIR_IDX_PA_EDGE   8'h06
`define UIR_IDX_PB_EDGE   8'h07
`define UIR_IDX_GLB_EN    8'h20
`define UIR_IDX_EP_EN     8'h21
`define UIR_IDX_CTRL      8'h30
`define UIR_IDX_STATUS    8'h31
`define UIR_IDX_DEV_ADDR  8'h32
`define UIR_IDX_SPI_DATA  8'h33

`define UIR_GLB_SPI       3
`define UIR_GLB_T1024     2
`define UIR_GLB_T128      1
`define UIR_GLB_BRST      0
`define UIR_CTRL_PS2      0
`define UIR_ST_TCF        0
`define UIR_ST_COND       1
`define UIR_ST_EVENT      2
`define UIR_ST_LOCK       3

`define UIR_RST_BYTE      8'h00
`define UIR_RST_GLB       4'h0
`define UIR_RST_EP        3'h0
`define UIR_RST_ADDR      7'h00

`endif

// ===== verilog/uir_pkg.sv
// Types shared by the interrupt source block
package uir_pkg;
    typedef logic [7:0] uir_byte_t;
    typedef enum logic [1:0] {BRD_IDLE, BRD_COUNT, BRD_DETECT} uir_brd_state_t;
endpackage

// ===== verilog/uir_irq_sources.sv
// Interrupt sources: SPI, periodic timers, bus reset / PS/2, endpoints, GPIO pins
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/100ps
`include "uir_cfg.svh"

module uir_irq_sources
    import uir_pkg::*;
#(
    parameter int T128_CYC = `UIR_T128_CYC,
    parameter int BRST_CYC = `UIR_BRST_CYC
) (
    input  wire logic        clk_i,             // 40 MHz clock
    input  wire logic        rst_i,             // Synchronous reset, high
    input  wire logic        wb_cyc_i,          // Wishbone cycle
    input  wire logic        wb_stb_i,          // Wishbone strobe
    input  wire logic        wb_we_i,           // Wishbone write
    input  wire logic [9:0]  wb_adr_i,          // Byte address
    input  wire logic [3:0]  wb_sel_i,          // Byte lanes
    input  wire logic [31:0] wb_dat_i,          // Write data
    output logic      [31:0] wb_dat_o,          // Read data
    output logic             wb_ack_o,          // Acknowledge
    input  wire logic        spi_byte_done_i,   // Pulse at last SPI edge
    input  wire logic [7:0]  spi_rx_byte_i,     // Received SPI byte
    input  wire logic        usb_dp_i,          // USB D+ level
    input  wire logic        usb_dm_i,          // USB D- level
    input  wire logic        ps2_data_pin_i,    // PS/2 data level
    input  wire logic [2:0]  ep_data_valid_i,   // Pulse: valid host data
    input  wire logic [2:0]  ep_data_any_i,     // Pulse: any data packet
    input  wire logic [2:0]  ep_ack_out_mode_i, // Level: endpoint in ACK OUT mode
    input  wire logic [2:0]  ep_nak_stall_i,    // Pulse: NAK or STALL sent
    input  wire logic [2:0]  ep_in_ack_i,       // Pulse: host ACK after IN
    input  wire logic        ctl_ep_setup_i,    // Pulse: mode set to accept SETUP
    input  wire logic        ctl_ep_zlp_i,      // Pulse: status-stage ZLP sent
    input  wire logic [7:0]  gpio_a_i,          // First GPIO port pins
    input  wire logic [7:0]  gpio_b_i,          // Second GPIO port pins
    output logic             irq_busrst_o,      // Bus reset / PS/2 pulse
    output logic             irq_t128_o,        // 128 us timer pulse
    output logic             irq_t1024_o,       // 1.024 ms timer pulse
    output logic      [2:0]  irq_ep_o,          // Endpoint pulses
    output logic             irq_spi_o,         // SPI pulse
    output logic             irq_gpio_o,        // Shared GPIO pulse
    output logic      [6:0]  usb_dev_addr_o     // USB device address
);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////////
    // Register bus

    uir_byte_t      pa_en_ff, pb_en_ff, pa_edge_ff, pb_edge_ff;
    uir_byte_t      nxt_pa_en, nxt_pb_en, nxt_pa_edge, nxt_pb_edge;
    logic [3:0]     glb_en_ff, nxt_glb_en;
    logic [2:0]     ep_en_ff, nxt_ep_en;
    logic           ps2_mode_ff, nxt_ps2_mode;
    logic [6:0]     dev_addr_ff, nxt_dev_addr;
    uir_byte_t      spi_data_ff, nxt_spi_data;
    logic           tcf_ff, nxt_tcf;
    logic           ack_ff, nxt_ack;
    logic [31:0]    dat_ff, nxt_dat;
    logic           wr_fire, rd_fire;
    uir_byte_t      rd_val;
    logic [7:0]     idx;
    uir_brd_state_t st_ff, nxt_st;
    logic           bus_cond;
    logic           lock_ff;

    always_comb begin
        idx          = wb_adr_i[9:2];
        wr_fire      = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff & wb_sel_i[0];
        rd_fire      = wb_cyc_i & wb_stb_i & ~wb_we_i & ack_ff;
        nxt_ack      = wb_cyc_i & wb_stb_i & ~ack_ff;
        nxt_pa_en    = pa_en_ff;
        nxt_pb_en    = pb_en_ff;
        nxt_pa_edge  = pa_edge_ff;
        nxt_pb_edge  = pb_edge_ff;
        nxt_glb_en   = glb_en_ff;
        nxt_ep_en    = ep_en_ff;
        nxt_ps2_mode = ps2_mode_ff;
        nxt_dev_addr = dev_addr_ff;
        nxt_spi_data = spi_data_ff;
        nxt_tcf      = tcf_ff;
        if (wr_fire) begin
            case (idx)
                `UIR_IDX_PA_EN:    nxt_pa_en = wb_dat_i[7:0];
                `UIR_IDX_PB_EN:    nxt_pb_en = wb_dat_i[7:0];
                `UIR_IDX_PA_EDGE:  nxt_pa_edge = wb_dat_i[7:0];
                `UIR_IDX_PB_EDGE:  nxt_pb_edge = wb_dat_i[7:0];
                `UIR_IDX_GLB_EN:   nxt_glb_en = wb_dat_i[3:0];
                `UIR_IDX_EP_EN:    nxt_ep_en = wb_dat_i[2:0];
                `UIR_IDX_CTRL:     nxt_ps2_mode = wb_dat_i[`UIR_CTRL_PS2];
                `UIR_IDX_DEV_ADDR: nxt_dev_addr = wb_dat_i[6:0];
                default: ;
            endcase
        end
        // Clear by reading the data; a new byte in the same cycle wins
        if (rd_fire && idx == `UIR_IDX_SPI_DATA) begin
            nxt_tcf = 1'b0;
        end
        if (spi_byte_done_i) begin
            nxt_spi_data = spi_rx_byte_i;
            nxt_tcf      = 1'b1;
        end
        if (st_ff == BRD_DETECT) begin
            nxt_dev_addr = `UIR_RST_ADDR;
        end
        // Pin enable and edge registers are write-only and read zero
        case (idx)
            `UIR_IDX_GLB_EN:   rd_val = {4'h0, glb_en_ff};
            `UIR_IDX_EP_EN:    rd_val = {5'h00, ep_en_ff};
            `UIR_IDX_CTRL:     rd_val = {7'h00, ps2_mode_ff};
            `UIR_IDX_STATUS:   rd_val = {4'h0, lock_ff, st_ff == BRD_DETECT, bus_cond, tcf_ff};
            `UIR_IDX_DEV_ADDR: rd_val = {1'b0, dev_addr_ff};
            `UIR_IDX_SPI_DATA: rd_val = spi_data_ff;
            default:           rd_val = `UIR_RST_BYTE;
        endcase
        nxt_dat = nxt_ack ? {24'h000000, rd_val} : 32'h00000000;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_en_ff    <= `UIR_RST_BYTE;
            pb_en_ff    <= `UIR_RST_BYTE;
            pa_edge_ff  <= `UIR_RST_BYTE;
            pb_edge_ff  <= `UIR_RST_BYTE;
            glb_en_ff   <= `UIR_RST_GLB;
            ep_en_ff    <= `UIR_RST_EP;
            ps2_mode_ff <= 1'b0;
            dev_addr_ff <= `UIR_RST_ADDR;
            spi_data_ff <= `UIR_RST_BYTE;
            tcf_ff      <= 1'b0;
            ack_ff      <= 1'b0;
            dat_ff      <= 32'h00000000;
        end else begin
            pa_en_ff    <= nxt_pa_en;
            pb_en_ff    <= nxt_pb_en;
            pa_edge_ff  <= nxt_pa_edge;
            pb_edge_ff  <= nxt_pb_edge;
            glb_en_ff   <= nxt_glb_en;
            ep_en_ff    <= nxt_ep_en;
            ps2_mode_ff <= nxt_ps2_mode;
            dev_addr_ff <= nxt_dev_addr;
            spi_data_ff <= nxt_spi_data;
            tcf_ff      <= nxt_tcf;
            ack_ff      <= nxt_ack;
            dat_ff      <= nxt_dat;
        end
    end

    assign wb_ack_o       = ack_ff;
    assign wb_dat_o       = dat_ff;
    assign usb_dev_addr_o = dev_addr_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Free-running timer

    logic [15:0] t_cnt_ff, nxt_t_cnt;
    logic [2:0]  t_sub_ff, nxt_t_sub;
    logic        tick128, tick1024;

    always_comb begin
        tick128   = (t_cnt_ff == 16'(T128_CYC - 1));
        tick1024  = tick128 && (t_sub_ff == 3'(`UIR_T1024_DIV - 1));
        nxt_t_cnt = tick128 ? 16'h0000 : t_cnt_ff + 16'h0001;
        nxt_t_sub = tick128 ? t_sub_ff + 3'h1 : t_sub_ff;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            t_cnt_ff <= 16'h0000;
            t_sub_ff <= 3'h0;
        end else begin
            t_cnt_ff <= nxt_t_cnt;
            t_sub_ff <= nxt_t_sub;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus reset / PS/2 activity detector

    logic [15:0] brd_cnt_ff, nxt_brd_cnt;
    logic        brd_fire;

    always_comb begin
        // PS/2 mode watches data low, USB mode watches SE0
        bus_cond    = ps2_mode_ff ? ~ps2_data_pin_i : (~usb_dp_i & ~usb_dm_i);
        nxt_st      = st_ff;
        nxt_brd_cnt = brd_cnt_ff;
        brd_fire    = 1'b0;
        case (st_ff)
            BRD_IDLE: begin
                if (bus_cond) begin
                    nxt_st      = BRD_COUNT;
                    nxt_brd_cnt = 16'h0001;
                end
            end
            BRD_COUNT: begin
                if (!bus_cond) begin
                    nxt_st = BRD_IDLE;
                end else if (brd_cnt_ff == 16'(BRST_CYC - 1)) begin
                    nxt_st   = BRD_DETECT;
                    brd_fire = ps2_mode_ff;
                end else begin
                    nxt_brd_cnt = brd_cnt_ff + 16'h0001;
                end
            end
            BRD_DETECT: begin
                // Firing right at the end keeps well inside the allowed lag
                if (!bus_cond) begin
                    nxt_st   = BRD_IDLE;
                    brd_fire = ~ps2_mode_ff;
                end
            end
            default: nxt_st = BRD_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff      <= BRD_IDLE;
            brd_cnt_ff <= 16'h0000;
        end else begin
            st_ff      <= nxt_st;
            brd_cnt_ff <= nxt_brd_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // GPIO pin interrupt with single-pin lock

    logic [15:0] pin_all, pin_en, pin_act, pin_rise;
    logic [15:0] act_prev_ff, nxt_act_prev;
    logic [3:0]  lock_idx_ff, nxt_lock_idx;
    logic        nxt_lock, lock_rel, gpio_fire, hit;
    logic [3:0]  hit_idx;

    assign pin_all = {gpio_b_i, gpio_a_i};
    assign pin_en  = {pb_en_ff, pa_en_ff};

    for (genvar g = 0; g < 16; g++) begin : g_pin
        logic edge_sel;
        assign edge_sel    = (g < 8) ? pa_edge_ff[g % 8] : pb_edge_ff[g % 8];
        assign pin_act[g]  = edge_sel ? pin_all[g] : ~pin_all[g];
        assign pin_rise[g] = pin_en[g] & pin_act[g] & ~act_prev_ff[g];
    end

    always_comb begin
        nxt_act_prev = pin_act;
        hit          = 1'b0;
        hit_idx      = 4'h0;
        // Lowest pin wins when several trigger together
        for (int i = 15; i >= 0; i--) begin
            if (pin_rise[i]) begin
                hit     = 1'b1;
                hit_idx = 4'(i);
            end
        end
        lock_rel     = lock_ff & (~pin_act[lock_idx_ff] | ~pin_en[lock_idx_ff]);
        nxt_lock     = lock_ff & ~lock_rel;
        nxt_lock_idx = lock_idx_ff;
        gpio_fire    = 1'b0;
        if ((!lock_ff || lock_rel) && hit) begin
            nxt_lock     = 1'b1;
            nxt_lock_idx = hit_idx;
            gpio_fire    = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_prev_ff <= 16'h0000;
            lock_ff     <= 1'b0;
            lock_idx_ff <= 4'h0;
        end else begin
            act_prev_ff <= nxt_act_prev;
            lock_ff     <= nxt_lock;
            lock_idx_ff <= nxt_lock_idx;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt outputs

    logic [2:0] ep_evt, nxt_irq_ep;
    logic       nxt_irq_busrst, nxt_irq_t128, nxt_irq_t1024, nxt_irq_spi;

    for (genvar e = 0; e < 3; e++) begin : g_ep
        logic own_evt;
        if (e == 0) begin : g_ctl
            assign own_evt = ctl_ep_setup_i | ctl_ep_zlp_i;
        end else begin : g_data
            assign own_evt = ep_in_ack_i[e];
        end
        // ACK OUT modes fire on any packet, even a bad CRC
        assign ep_evt[e] = ep_data_valid_i[e] | (ep_ack_out_mode_i[e] & ep_data_any_i[e])
                         | ep_nak_stall_i[e] | own_evt;
    end

    always_comb begin
        nxt_irq_busrst = brd_fire & glb_en_ff[`UIR_GLB_BRST];
        nxt_irq_t128   = tick128 & glb_en_ff[`UIR_GLB_T128];
        nxt_irq_t1024  = tick1024 & glb_en_ff[`UIR_GLB_T1024];
        nxt_irq_spi    = spi_byte_done_i & glb_en_ff[`UIR_GLB_SPI];
        nxt_irq_ep     = ep_evt & ep_en_ff;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_busrst_o <= 1'b0;
            irq_t128_o   <= 1'b0;
            irq_t1024_o  <= 1'b0;
            irq_spi_o    <= 1'b0;
            irq_ep_o     <= 3'h0;
            irq_gpio_o   <= 1'b0;
        end else begin
            irq_busrst_o <= nxt_irq_busrst;
            irq_t128_o   <= nxt_irq_t128;
            irq_t1024_o  <= nxt_irq_t1024;
            irq_spi_o    <= nxt_irq_spi;
            irq_ep_o     <= nxt_irq_ep;
            irq_gpio_o   <= gpio_fire;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    logic [15:0] gap_ff;
    logic        gap_seen_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap_ff      <= 16'h0000;
            gap_seen_ff <= 1'b0;
        end else begin
            gap_ff      <= tick128 ? 16'h0000 : gap_ff + 16'h0001;
            gap_seen_ff <= gap_seen_ff | tick128;
        end
    end

    chk_spi_irq_pulse: assert property (spi_byte_done_i && glb_en_ff[3] |=> irq_spi_o)
        else $error("SPI byte end did not raise interrupt");
    chk_spi_data_flag: assert property (
            spi_byte_done_i |=> tcf_ff && spi_data_ff == $past(spi_rx_byte_i))
        else $error("SPI byte or complete flag wrong");
    chk_t128_period: assert property (
            tick128 && gap_seen_ff |-> gap_ff == 16'(T128_CYC - 1))
        else $error("128 us tick period wrong");
    chk_t1024_nesting: assert property (
            irq_t1024_o |-> $past(t_sub_ff) == 3'h7 && $past(tick128))
        else $error("1.024 ms tick not on eighth 128 us tick");
    chk_brd_min_time: assert property (
            $rose(st_ff == BRD_DETECT) |->
            $past(brd_cnt_ff) == 16'(BRST_CYC - 1) && $past(bus_cond))
        else $error("Bus event detected at wrong time");
    chk_ps2_fire_now: assert property (
            $rose(st_ff == BRD_DETECT) && ps2_mode_ff && glb_en_ff[0] |->
            irq_busrst_o ##1 !irq_busrst_o)
        else $error("PS/2 interrupt not raised at detection");
    chk_usb_fire_end: assert property (
            st_ff == BRD_DETECT && !bus_cond && !ps2_mode_ff && glb_en_ff[0] |=>
            irq_busrst_o && st_ff == BRD_IDLE)
        else $error("USB reset interrupt not raised at SE0 end");
    chk_addr_held_clear: assert property (st_ff == BRD_DETECT |=> usb_dev_addr_o == 7'h00)
        else $error("Device address not cleared during bus event");
    chk_ep_nak_irq: assert property (ep_nak_stall_i[1] && ep_en_ff[1] |=> irq_ep_o[1])
        else $error("NAK or STALL did not interrupt endpoint");
    chk_gpio_lock_hold: assert property (lock_ff && !lock_rel |=> !irq_gpio_o)
        else $error("GPIO interrupt while another pin holds lock");

endmodule

// ===== bench/uir_bus_host_model.sv
// Host-side model of the USB and PS/2 bus lines seen by the detector
`timescale 1ns/100ps
module uir_bus_host_model (
    input  wire logic se0_req_i,     // Hold SE0 on the USB pair
    input  wire logic k_req_i,       // Drive K (D+ high, D- low)
    input  wire logic ps2_low_req_i, // Hold the PS/2 data line low
    output logic      usb_dp_o,      // USB D+ level
    output logic      usb_dm_o,      // USB D- level
    output logic      ps2_data_o     // PS/2 data, pulled up when released
);
    // Low-speed idle is J (D- high); K swaps the pair; SE0 pulls both lines low
    assign usb_dp_o   = k_req_i;
    assign usb_dm_o   = ~se0_req_i & ~k_req_i;
    // Released line goes to the pull-up level, never holds a stale low
    assign ps2_data_o = ~ps2_low_req_i;
endmodule

// ===== bench/test_usb_ps2_interrupt_sources.sv
// Self-checking bench for the interrupt source block
`timescale 1ns/100ps
module test_usb_ps2_interrupt_sources;
    import uir_pkg::*;
    localparam int T128 = 20;
    localparam int BRST = 16;
    typedef struct packed {
        logic [7:0] idx;
        logic [7:0] wd;
        logic       s0;
        logic [7:0] exp;
    } uir_row_t;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic [3:0]  sel = 4'h0;
    logic [9:0]  adr = 10'h000;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic        spi_done = 1'b0, se0 = 1'b0, ps2_low = 1'b0, k_st = 1'b0, dp, dm, ps2;
    logic [7:0]  spi_byte = 8'h00, gpa = 8'h00, gpb = 8'h00;
    logic [16:0] ev = 17'h0;
    logic [2:0]  ev_valid, ev_any, ack_mode, ev_nak, ev_in, irq_ep;
    logic        ev_setup, ev_zlp, irq_brst, irq_t128, irq_t1024, irq_spi, irq_gpio;
    logic [6:0]  dev_addr;
    int          err_count = 0, n_checks = 0, a, b, i;
    int          n_brst = 0, n_t128 = 0, n_t1024 = 0, n_gpio = 0;
    uir_row_t    rows [8];

    assign {ev_valid, ev_any, ack_mode, ev_nak, ev_in, ev_setup, ev_zlp} = ev;
    always #12.5 clk_i = ~clk_i;

    uir_bus_host_model u_host (.se0_req_i(se0), .k_req_i(k_st), .ps2_low_req_i(ps2_low),
        .usb_dp_o(dp), .usb_dm_o(dm), .ps2_data_o(ps2));

    uir_irq_sources #(.T128_CYC(T128), .BRST_CYC(BRST)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .spi_byte_done_i(spi_done), .spi_rx_byte_i(spi_byte), .usb_dp_i(dp),
        .usb_dm_i(dm), .ps2_data_pin_i(ps2), .ep_data_valid_i(ev_valid),
        .ep_data_any_i(ev_any), .ep_ack_out_mode_i(ack_mode), .ep_nak_stall_i(ev_nak),
        .ep_in_ack_i(ev_in), .ctl_ep_setup_i(ev_setup), .ctl_ep_zlp_i(ev_zlp),
        .gpio_a_i(gpa), .gpio_b_i(gpb), .irq_busrst_o(irq_brst), .irq_t128_o(irq_t128),
        .irq_t1024_o(irq_t1024), .irq_ep_o(irq_ep), .irq_spi_o(irq_spi),
        .irq_gpio_o(irq_gpio), .usb_dev_addr_o(dev_addr));

    // Pulse tallies; a pulse is counted at the edge that samples it
    always @(posedge clk_i) begin
        n_brst  <= n_brst + int'(irq_brst === 1'b1);
        n_t128  <= n_t128 + int'(irq_t128 === 1'b1);
        n_t1024 <= n_t1024 + int'(irq_t1024 === 1'b1);
        n_gpio  <= n_gpio + int'(irq_gpio === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Classic single cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      input logic s0);
        int n;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'b00};
        sel  <= {3'b111, s0};
        wdat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 16);
        if (ack !== 1'b1) begin
            chk("wb_ack", {31'h0, ack}, 32'h1);
            tally_and_finish();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d, 1'b1);
    endtask

    task automatic rd(input logic [7:0] idx);
        wb(1'b0, idx, 8'h00, 1'b0);
    endtask

    task automatic ep(input logic [16:0] e, input logic [2:0] exp);
        @(posedge clk_i);
        ev <= e;
        @(posedge clk_i);
        ev <= 17'h0;
        #1 chk("irq_ep", {29'h0, irq_ep}, {29'h0, exp});
    endtask

    task automatic spi(input logic [7:0] d, input logic exp);
        @(posedge clk_i);
        spi_done <= 1'b1;
        spi_byte <= d;
        @(posedge clk_i);
        spi_done <= 1'b0;
        #1 chk("irq_spi", {31'h0, irq_spi}, {31'h0, exp});
    endtask

    task automatic settle;
        repeat (4) @(posedge clk_i);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge clk_i);
        chk("run_time", 32'h1, 32'h0);
        tally_and_finish();
    end

    initial begin
        rows[0] = '{8'h20, 8'hff, 1'b1, 8'h0f};
        rows[1] = '{8'h21, 8'hff, 1'b1, 8'h07};
        rows[2] = '{8'h21, 8'h02, 1'b0, 8'h07};
        rows[3] = '{8'h21, 8'h05, 1'b1, 8'h05};
        rows[4] = '{8'h04, 8'hff, 1'b1, 8'h00};
        rows[5] = '{8'h06, 8'h5a, 1'b1, 8'h00};
        rows[6] = '{8'h3c, 8'h77, 1'b1, 8'h00};
        rows[7] = '{8'h20, 8'h00, 1'b1, 8'h00};
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        chk("irq_idle", {irq_brst, irq_t128, irq_t1024, irq_spi, irq_gpio, irq_ep}, 32'h0);
        rd(8'h20);
        chk("glb_reset", q, 32'h0);
        rd(8'h21);
        chk("ep_reset", q, 32'h0);
        for (i = 0; i < 8; i++) begin
            wb(1'b1, rows[i].idx, rows[i].wd, rows[i].s0);
            rd(rows[i].idx);
            chk("reg_readback", q, {24'h0, rows[i].exp});
        end
        // Timers: enables gate pulses, counter runs free
        wr(8'h20, 8'h06);
        for (i = 0; i < 200 && irq_t1024 !== 1'b1; i++) @(posedge clk_i);
        chk("t1024_seen", {31'h0, irq_t1024}, 32'h1);
        #1 a = n_t128;
        b = n_t1024;
        repeat (8 * T128 * 3) @(posedge clk_i);
        #1 chk("t128_count", n_t128 - a, 24);
        chk("t1024_count", n_t1024 - b, 3);
        wr(8'h20, 8'h00);
        a = n_t128 + n_t1024;
        repeat (200) @(posedge clk_i);
        #1 chk("timer_masked", n_t128 + n_t1024 - a, 0);
        // SPI byte end: pulse, flag, data, then masked
        wr(8'h20, 8'h08);
        spi(8'ha5, 1'b1);
        rd(8'h31);
        chk("tcf_set", q & 32'h1, 32'h1);
        rd(8'h33);
        chk("spi_byte", q, 32'ha5);
        rd(8'h31);
        chk("tcf_clear", q & 32'h1, 32'h0);
        wr(8'h20, 8'h01);
        spi(8'h3c, 1'b0);
        // USB mode: short SE0 ignored, long SE0 fires at its end
        wr(8'h30, 8'h00);
        wr(8'h32, 8'h55);
        rd(8'h32);
        chk("dev_addr", q, 32'h55);
        a = n_brst;
        // A long K state is not SE0 and must never fire
        @(posedge clk_i);
        k_st <= 1'b1;
        repeat (BRST + 4) @(posedge clk_i);
        k_st <= 1'b0;
        repeat (4) @(posedge clk_i);
        #1 chk("brst_k_state", n_brst - a, 0);
        @(posedge clk_i);
        se0 <= 1'b1;
        repeat (BRST - 6) @(posedge clk_i);
        se0 <= 1'b0;
        repeat (20) @(posedge clk_i);
        se0 <= 1'b1;
        repeat (BRST / 2 - 2) @(posedge clk_i);
        #1 chk("brst_short", n_brst - a, 0);
        repeat (BRST + 2) @(posedge clk_i);
        #1 chk("brst_in_se0", n_brst - a, 0);
        chk("addr_cleared", {25'h0, dev_addr}, 32'h0);
        @(posedge clk_i);
        se0 <= 1'b0;
        for (i = 0; i < BRST / 2 + 1 && n_brst == a; i++) @(posedge clk_i);
        #1 chk("brst_se0_end", n_brst - a, 1);
        // PS/2 mode: fires while data still low
        wr(8'h30, 8'h01);
        wr(8'h32, 8'h2a);
        rd(8'h32);
        chk("dev_addr_ps2", q, 32'h2a);
        a = n_brst;
        @(posedge clk_i);
        ps2_low <= 1'b1;
        repeat (BRST - 2) @(posedge clk_i);
        #1 chk("ps2_early", n_brst - a, 0);
        repeat (8) @(posedge clk_i);
        #1 chk("ps2_low", n_brst - a, 1);
        chk("addr_cleared", {25'h0, dev_addr}, 32'h0);
        @(posedge clk_i);
        ps2_low <= 1'b0;
        // Endpoints 0 and 2 enabled, endpoint 1 masked
        ep({3'h7, 14'h0}, 3'h5);
        ep({3'h0, 3'h7, 11'h0}, 3'h0);
        ep({6'h0, 3'h7, 8'h0}, 3'h0);
        ep({3'h0, 3'h7, 3'h7, 8'h0}, 3'h5);
        ep({9'h0, 3'h7, 5'h0}, 3'h5);
        ep({12'h0, 3'h7, 2'h0}, 3'h4);
        ep({15'h0, 2'b10}, 3'h1);
        ep({15'h0, 2'b01}, 3'h1);
        // GPIO: pin 0 rising, pin 1 falling, lock between pins
        wr(8'h04, 8'h00);
        wr(8'h06, 8'h01);
        @(posedge clk_i);
        gpa <= 8'h02;
        wr(8'h04, 8'h03);
        a = n_gpio;
        @(posedge clk_i);
        gpa <= 8'h03;
        settle();
        chk("gpio_rise", n_gpio - a, 1);
        gpa <= 8'h01;
        settle();
        chk("gpio_locked", n_gpio - a, 1);
        gpa <= 8'h00;
        settle();
        gpa <= 8'h02;
        settle();
        gpa <= 8'h00;
        settle();
        chk("gpio_fall", n_gpio - a, 2);
        gpa <= 8'h02;
        wr(8'h07, 8'h00);
        @(posedge clk_i);
        gpb <= 8'hff;
        wr(8'h05, 8'h80);
        @(posedge clk_i);
        gpb <= 8'h7f;
        settle();
        chk("gpio_port_b", n_gpio - a, 3);
        // Reset in mid-run clears the enables again
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h21);
        chk("ep_rerst", q, 32'h0);
        tally_and_finish();
    end
endmodule
